// >>> pkg/ahbi_pkg.sv
// Constants and types shared by both ends of the host bus port.
// Assumes one clock for both ends and byte-wide device registers.
package ahbi_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int N_COND = 18;
  localparam int N_PIN = 19;
  // Clock edges between select and acknowledge.
  localparam logic [1:0] ACK_EDGES = 2'h2;
  // Device register addresses: channel A at 0x00, channel B at 0x08.
  localparam logic [2:0] CH_MODE = 3'h0;
  localparam logic [2:0] CH_STAT = 3'h1;
  localparam logic [2:0] CH_BAUD = 3'h2;
  localparam logic [6:0] ADDR_IMR0 = 7'h10;
  localparam logic [6:0] ADDR_IMR1 = 7'h11;
  localparam logic [6:0] ADDR_IMR2 = 7'h12;
  localparam logic [6:0] ADDR_ISR0 = 7'h13;
  localparam logic [6:0] ADDR_ISR1 = 7'h14;
  localparam logic [6:0] ADDR_ISR2 = 7'h15;
  localparam logic [6:0] ADDR_OPR = 7'h20;
  localparam logic [6:0] ADDR_OUT_PORT_CONFIG_REG = 7'h21;
  localparam logic [6:0] ADDR_IOIN_A = 7'h22;
  localparam logic [6:0] ADDR_IOIN_B = 7'h23;
  localparam logic [6:0] ADDR_VECTOR = 7'h30;
  localparam logic [6:0] ADDR_BUSCFG = 7'h31;
  localparam logic [6:0] ADDR_CT_CTRL = 7'h38;
  localparam logic [6:0] ADDR_CT_LO = 7'h39;
  localparam logic [6:0] ADDR_CT_HI = 7'h3a;
  // Reset values: 8 data bits, no parity, 1 stop bit, 9600 baud code.
  localparam logic [7:0] MODE1_RST = 8'h13;
  localparam logic [7:0] MODE2_RST = 8'h07;
  localparam logic [7:0] BAUD_RST = 8'hbb;
  localparam logic [7:0] VECTOR_RST = 8'h0f;
  localparam logic [18:0] PIN_RST = 19'h7_ffff;
  localparam logic MARK = 1'b1;
  // Controller registers on AXI4-Lite, byte offsets.
  localparam logic [4:0] HOFS_CMD = 5'h00;
  localparam logic [4:0] HOFS_RESULT = 5'h04;
  localparam logic [4:0] HOFS_INT_STATUS = 5'h08;
  localparam logic [4:0] HOFS_INT_MASK = 5'h0c;
  localparam logic [4:0] HOFS_DEV_CTRL = 5'h10;
  localparam int CMD_READ_BIT = 8;
  localparam int CMD_IACK_BIT = 9;
  localparam int CMD_WDATA_LSB = 16;
  localparam int INT_DONE = 0;
  localparam int INT_IRQ = 1;
  localparam logic DEV_RUN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_WAIT = 2'b01,
    HST_END = 2'b10
  } ahbi_hst_state_t;
endpackage : ahbi_pkg

// >>> pkg/ahbi_port_if.sv
// Parallel host port between the controller and the device.
// Assumes both ends are clocked by the same aclk; the open-drain and
// three-state lines are resolved here, with pull-ups when undriven.
`timescale 1ns/10ps
interface ahbi_port_if;
  logic chip_select_n;
  logic read_write_dir;
  logic int_ack_n;
  logic reset_in_n;
  logic [6:0] reg_select_addr;
  logic [7:0] data_host_out;
  logic data_host_oe_n;
  logic [7:0] data_dev_out;
  logic data_dev_oe_n;
  logic ack_out;
  logic ack_oe_n;
  logic irq_out;
  logic irq_oe_n;
  wire [7:0] host_data_bus;
  wire transfer_ack_n;
  wire int_request_n;
  assign host_data_bus = !data_dev_oe_n ? data_dev_out :
                         (!data_host_oe_n ? data_host_out : 8'hff);
  assign transfer_ack_n = ack_oe_n ? 1'b1 : ack_out;
  assign int_request_n = irq_oe_n ? 1'b1 : irq_out;
  modport device (
    input chip_select_n, read_write_dir, int_ack_n, reset_in_n,
    input reg_select_addr, host_data_bus,
    output data_dev_out, data_dev_oe_n, ack_out, ack_oe_n, irq_out, irq_oe_n
  );
  modport host (
    output chip_select_n, read_write_dir, int_ack_n, reset_in_n,
    output reg_select_addr, data_host_out, data_host_oe_n,
    input host_data_bus, transfer_ack_n, int_request_n
  );
endinterface : ahbi_port_if

// >>> src/ahbi_device.sv
// Device end of the host bus port: acknowledge-mode bus slave, register
// file, reset defaults of the serial channels, I/O pins and timer.
// Assumes the controller holds address, direction and data stable while
// selected, and leaves at least one idle cycle between accesses.
//
// Summary of operation
// - Format pin low selects acknowledge bus mode.
// - Eight-bit data bus, bit zero least significant.
// - Selected transfers data; deselected releases data bus.
// - Direction line high reads, low writes.
// - Seven-bit address selects the register accessed.
// - Interrupt acknowledge drives vector and acknowledges.
// - Open-drain acknowledge marks completed transfers.
// - Reset clears status, masks, interrupts, output port.
// - Reset floats all I/O pins, halts timer.
// - Reset idles channels, transmit lines at mark.
// - Reset points at first mode register, 9600 8N1.
// - Interrupt request low while unmasked condition true.
// - Serial input least bit first, high is mark.
// - Acknowledge no sooner than two clock edges.
// - Without pin or programming, strobe format default.
// - Transmit line held at mark when idle.
`timescale 1ns/10ps
module ahbi_device (
  input wire logic aclk,
  input wire logic aresetn,
  ahbi_port_if.device bus,
  input wire logic bus_fmt_sel,
  input wire logic rxd_a,
  input wire logic rxd_b,
  input wire logic [16:0] int_cond,
  input wire logic [15:0] io_in,
  output logic txd_a,
  output logic txd_b,
  output logic [15:0] io_out,
  output logic [15:0] io_oe_n
);
  logic rst;
  logic [18:0] s1;
  logic [18:0] s2;
  logic [18:0] s3;
  logic [18:0] filt;
  logic [18:0] next_filt;
  logic [1:0] edge_cnt;
  logic [7:0] rd_q;
  logic [7:0] mode1 [2];
  logic [7:0] mode2 [2];
  logic [7:0] baud [2];
  logic [1:0] ptr;
  logic [1:0] space;
  logic [17:0] int_mask_reg;
  logic [17:0] int_status_reg;
  logic [7:0] out_port_reg;
  logic [7:0] out_port_config_reg;
  logic [7:0] vector;
  logic [7:0] bus_cfg;
  logic ct_run;
  logic ct_flag;
  logic [15:0] ct_cnt;

  // Either the pin or the controller may hold the device in reset.
  assign rst = !aresetn || !bus.reset_in_n;

  // Pins from outside the clock domain; a change counts once two stages agree.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1 <= ahbi_pkg::PIN_RST;
      s2 <= ahbi_pkg::PIN_RST;
      s3 <= ahbi_pkg::PIN_RST;
      filt <= ahbi_pkg::PIN_RST;
    end
    else
    begin
      s1 <= {io_in, bus_fmt_sel, rxd_b, rxd_a};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end
  assign next_filt = (s2 & s3) | (filt & (s2 | s3));

  wire [6:0] a = bus.reg_select_addr;
  wire [7:0] wdat = bus.host_data_bus;
  wire ack_mode = !filt[2] || bus_cfg[0];
  wire cs = !bus.chip_select_n;
  wire iack = !bus.int_ack_n;
  wire active = ack_mode && (cs || iack);
  wire rd_cyc = iack || bus.read_write_dir;
  wire commit = active && (edge_cnt == ahbi_pkg::ACK_EDGES - 2'h1);
  wire wr_stb = commit && cs && !iack && !bus.read_write_dir;
  wire rd_stb = commit && rd_cyc;
  wire acked = active && (edge_cnt == ahbi_pkg::ACK_EDGES);

  always_ff @(posedge aclk)
  begin
    if (rst || !active)
      edge_cnt <= 2'h0;
    else if (edge_cnt != ahbi_pkg::ACK_EDGES)
      edge_cnt <= edge_cnt + 2'h1;
  end

  wire in_chan = (a[6:4] == 3'h0);
  wire ch = a[3];
  wire [2:0] lo = a[2:0];
  wire [7:0] chan_rd = (lo == ahbi_pkg::CH_MODE) ? (ptr[ch] ? mode2[ch] : mode1[ch]) :
                       (lo == ahbi_pkg::CH_STAT) ? {6'h00, filt[ch], space[ch]} :
                       (lo == ahbi_pkg::CH_BAUD) ? baud[ch] : 8'h00;
  wire [7:0] rd_mux =
    in_chan ? chan_rd :
    (a == ahbi_pkg::ADDR_IMR0) ? int_mask_reg[7:0] :
    (a == ahbi_pkg::ADDR_IMR1) ? int_mask_reg[15:8] :
    (a == ahbi_pkg::ADDR_IMR2) ? {6'h00, int_mask_reg[17:16]} :
    (a == ahbi_pkg::ADDR_ISR0) ? int_status_reg[7:0] :
    (a == ahbi_pkg::ADDR_ISR1) ? int_status_reg[15:8] :
    (a == ahbi_pkg::ADDR_ISR2) ? {6'h00, int_status_reg[17:16]} :
    (a == ahbi_pkg::ADDR_OPR) ? out_port_reg :
    (a == ahbi_pkg::ADDR_OUT_PORT_CONFIG_REG) ? out_port_config_reg :
    (a == ahbi_pkg::ADDR_IOIN_A) ? filt[10:3] :
    (a == ahbi_pkg::ADDR_IOIN_B) ? filt[18:11] :
    (a == ahbi_pkg::ADDR_VECTOR) ? vector :
    (a == ahbi_pkg::ADDR_BUSCFG) ? bus_cfg :
    (a == ahbi_pkg::ADDR_CT_CTRL) ? {6'h00, ct_flag, ct_run} :
    (a == ahbi_pkg::ADDR_CT_LO) ? ct_cnt[7:0] :
    (a == ahbi_pkg::ADDR_CT_HI) ? ct_cnt[15:8] : 8'h00;

  always_ff @(posedge aclk)
  begin
    if (rst)
      rd_q <= 8'h00;
    else if (rd_stb)
      rd_q <= iack ? vector : rd_mux;
  end

  assign bus.data_dev_out = rd_q;
  assign bus.data_dev_oe_n = !(active && rd_cyc);
  assign bus.ack_out = 1'b0;
  assign bus.ack_oe_n = !acked;

  genvar g;
  for (g = 0; g < 2; g++)
  begin : g_chan
    wire hit = in_chan && (ch == 1'(g));
    wire mode_hit = hit && (lo == ahbi_pkg::CH_MODE);
    always_ff @(posedge aclk)
    begin
      if (rst)
      begin
        mode1[g] <= ahbi_pkg::MODE1_RST;
        mode2[g] <= ahbi_pkg::MODE2_RST;
        baud[g] <= ahbi_pkg::BAUD_RST;
        ptr[g] <= 1'b0;
        space[g] <= 1'b0;
      end
      else
      begin
        if (mode_hit && (wr_stb || rd_stb))
          ptr[g] <= 1'b1;
        if (mode_hit && wr_stb && !ptr[g])
          mode1[g] <= wdat;
        if (mode_hit && wr_stb && ptr[g])
          mode2[g] <= wdat;
        if (hit && lo == ahbi_pkg::CH_BAUD && wr_stb)
          baud[g] <= wdat;
        space[g] <= !filt[g] || (space[g] && !(hit && lo == ahbi_pkg::CH_STAT && wr_stb));
      end
    end
  end

  // Software registers; the interrupt status follows the live conditions.
  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      int_mask_reg <= 18'h0_0000;
      int_status_reg <= 18'h0_0000;
      out_port_reg <= 8'h00;
      out_port_config_reg <= 8'h00;
      vector <= ahbi_pkg::VECTOR_RST;
      bus_cfg <= 8'h00;
    end
    else
    begin
      int_status_reg <= {ct_flag, int_cond};
      if (wr_stb && a == ahbi_pkg::ADDR_IMR0)
        int_mask_reg[7:0] <= wdat;
      if (wr_stb && a == ahbi_pkg::ADDR_IMR1)
        int_mask_reg[15:8] <= wdat;
      if (wr_stb && a == ahbi_pkg::ADDR_IMR2)
        int_mask_reg[17:16] <= wdat[1:0];
      if (wr_stb && a == ahbi_pkg::ADDR_OPR)
        out_port_reg <= wdat;
      if (wr_stb && a == ahbi_pkg::ADDR_OUT_PORT_CONFIG_REG)
        out_port_config_reg <= wdat;
      if (wr_stb && a == ahbi_pkg::ADDR_VECTOR)
        vector <= wdat;
      if (wr_stb && a == ahbi_pkg::ADDR_BUSCFG)
        bus_cfg <= wdat;
    end
  end

  // The timer wraps through zero rather than stopping, so a late clear of
  // its flag never loses the next pass.
  wire ct_ctrl_wr = wr_stb && (a == ahbi_pkg::ADDR_CT_CTRL);
  wire ct_wrap = ct_run && (ct_cnt == 16'h0000);
  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      ct_run <= 1'b0;
      ct_flag <= 1'b0;
      ct_cnt <= 16'h0000;
    end
    else
    begin
      if (ct_ctrl_wr)
        ct_run <= wdat[0];
      ct_flag <= ct_wrap || (ct_flag && !ct_ctrl_wr);
      if (wr_stb && a == ahbi_pkg::ADDR_CT_LO)
        ct_cnt[7:0] <= wdat;
      else if (wr_stb && a == ahbi_pkg::ADDR_CT_HI)
        ct_cnt[15:8] <= wdat;
      else if (ct_run)
        ct_cnt <= ct_cnt - 16'h0001;
    end
  end

  assign bus.irq_out = 1'b0;
  assign bus.irq_oe_n = !(|(int_status_reg & int_mask_reg));
  assign io_out = {8'h00, out_port_reg};
  assign io_oe_n = {8'hff, ~out_port_config_reg};
  assign txd_a = ahbi_pkg::MARK;
  assign txd_b = ahbi_pkg::MARK;
endmodule : ahbi_device

// >>> src/ahbi_host.sv
// Controller end of the host bus port, ordered over AXI4-Lite.
// Assumes the device acknowledges every access it takes; a device that
// never answers leaves the controller busy until reset.
`timescale 1ns/10ps
module ahbi_host (
  input wire logic aclk,
  input wire logic aresetn,
  ahbi_port_if.host bus,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  ahbi_pkg::ahbi_hst_state_t state;
  logic aw_held;
  logic w_held;
  logic [4:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] rd_data;
  logic [1:0] int_status;
  logic [1:0] int_mask;
  logic dev_run;
  logic cs_n;
  logic iack_n;
  logic rw;
  logic [6:0] addr;
  logic [7:0] dout;
  logic dout_oe_n;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_wr = aw_held && w_held && !s_axi_bvalid;
  wire [31:0] wbe = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wval = w_data & wbe;
  wire wr_map = aw_addr inside {ahbi_pkg::HOFS_CMD, ahbi_pkg::HOFS_RESULT,
    ahbi_pkg::HOFS_INT_STATUS, ahbi_pkg::HOFS_INT_MASK, ahbi_pkg::HOFS_DEV_CTRL};
  wire busy = (state != ahbi_pkg::HST_IDLE);
  wire start = do_wr && aw_addr == ahbi_pkg::HOFS_CMD && w_strb[0] && !busy;
  wire got_ack = (state == ahbi_pkg::HST_WAIT) && !bus.transfer_ack_n;
  wire [1:0] int_set = {!bus.int_request_n, got_ack};
  wire [1:0] int_clr = (do_wr && aw_addr == ahbi_pkg::HOFS_INT_STATUS) ? wval[1:0] : 2'h0;
  wire [4:0] ar = s_axi_araddr[4:0];
  wire [31:0] rd_mux =
    (ar == ahbi_pkg::HOFS_CMD) ? {8'h00, dout, 6'h00, !iack_n, rw, 1'b0, addr} :
    (ar == ahbi_pkg::HOFS_RESULT) ? {22'h00_0000, !bus.int_request_n, busy, rd_data} :
    (ar == ahbi_pkg::HOFS_INT_STATUS) ? {30'h0000_0000, int_status} :
    (ar == ahbi_pkg::HOFS_INT_MASK) ? {30'h0000_0000, int_mask} :
    (ar == ahbi_pkg::HOFS_DEV_CTRL) ? {31'h0000_0000, dev_run} : 32'h0000_0000;
  wire rd_map = ar inside {ahbi_pkg::HOFS_CMD, ahbi_pkg::HOFS_RESULT,
    ahbi_pkg::HOFS_INT_STATUS, ahbi_pkg::HOFS_INT_MASK, ahbi_pkg::HOFS_DEV_CTRL};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ahbi_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[4:0];
      end
      else if (do_wr)
        aw_held <= 1'b0;
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_wr)
        w_held <= 1'b0;
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? ahbi_pkg::RESP_OKAY : ahbi_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ahbi_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_map ? ahbi_pkg::RESP_OKAY : ahbi_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_status <= 2'h0;
      int_mask <= 2'h0;
      dev_run <= ahbi_pkg::DEV_RUN_RST;
    end
    else
    begin
      int_status <= int_set | (int_status & ~int_clr);
      if (do_wr && aw_addr == ahbi_pkg::HOFS_INT_MASK)
        int_mask <= (int_mask & ~wbe[1:0]) | wval[1:0];
      if (do_wr && aw_addr == ahbi_pkg::HOFS_DEV_CTRL && w_strb[0])
        dev_run <= w_data[0];
    end
  end
  assign irq = |(int_status & int_mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ahbi_pkg::HST_IDLE;
      cs_n <= 1'b1;
      iack_n <= 1'b1;
      rw <= 1'b1;
      addr <= 7'h00;
      dout <= 8'h00;
      dout_oe_n <= 1'b1;
      rd_data <= 8'h00;
    end
    else
    begin
      unique case (state)
        ahbi_pkg::HST_IDLE:
        begin
          if (start)
          begin
            state <= ahbi_pkg::HST_WAIT;
            iack_n <= !w_data[ahbi_pkg::CMD_IACK_BIT];
            cs_n <= w_data[ahbi_pkg::CMD_IACK_BIT];
            rw <= w_data[ahbi_pkg::CMD_READ_BIT] || w_data[ahbi_pkg::CMD_IACK_BIT];
            addr <= w_data[6:0];
            dout <= w_data[ahbi_pkg::CMD_WDATA_LSB +: 8];
            dout_oe_n <= w_data[ahbi_pkg::CMD_READ_BIT] || w_data[ahbi_pkg::CMD_IACK_BIT];
          end
        end
        ahbi_pkg::HST_WAIT:
        begin
          if (got_ack)
          begin
            state <= ahbi_pkg::HST_END;
            cs_n <= 1'b1;
            iack_n <= 1'b1;
            dout_oe_n <= 1'b1;
            if (rw)
              rd_data <= bus.host_data_bus;
          end
        end
        ahbi_pkg::HST_END:
          state <= ahbi_pkg::HST_IDLE;
        default:
          state <= ahbi_pkg::HST_IDLE;
      endcase
    end
  end

  assign bus.chip_select_n = cs_n;
  assign bus.int_ack_n = iack_n;
  assign bus.read_write_dir = rw;
  assign bus.reg_select_addr = addr;
  assign bus.data_host_out = dout;
  assign bus.data_host_oe_n = dout_oe_n;
  assign bus.reset_in_n = dev_run;
endmodule : ahbi_host

// >>> tb/ahbi_port_props.sv
// Checker for the host port wires between controller and device.
// Assumes one shared aclk and a device held in acknowledge bus mode.
`timescale 1ns/10ps
module ahbi_port_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_select_n,
  input wire logic read_write_dir,
  input wire logic int_ack_n,
  input wire logic reset_in_n,
  input wire logic [6:0] reg_select_addr,
  input wire logic data_host_oe_n,
  input wire logic data_dev_oe_n,
  input wire logic transfer_ack_n,
  input wire logic int_request_n
);
  wire sel = !chip_select_n || !int_ack_n;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_idle_float;
    chip_select_n && int_ack_n |-> data_dev_oe_n;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("data bus driven while not selected");
  property p_rd_drive;
    !chip_select_n && int_ack_n && read_write_dir |-> !data_dev_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read cycle without device drive");
  property p_wr_float;
    !chip_select_n && int_ack_n && !read_write_dir |-> data_dev_oe_n && !data_host_oe_n;
  endproperty
  a_wr_float: assert property (p_wr_float)
    else $error("write cycle drive direction wrong");
  property p_no_fight;
    data_host_oe_n || data_dev_oe_n;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the data bus");
  property p_ack_early;
    $fell(transfer_ack_n) |-> $past(sel) && $past(sel, 2);
  endproperty
  a_ack_early: assert property (p_ack_early)
    else $error("acknowledge too soon after select");
  property p_ack_given;
    (sel && reset_in_n) [*3] |-> !transfer_ack_n;
  endproperty
  a_ack_given: assert property (p_ack_given)
    else $error("acknowledge missing");
  property p_ack_release;
    !transfer_ack_n |-> sel;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge held after select ended");
  property p_iack_vec;
    !int_ack_n && !transfer_ack_n |-> !data_dev_oe_n;
  endproperty
  a_iack_vec: assert property (p_iack_vec)
    else $error("vector not driven on acknowledge");
  property p_addr_hold;
    sel && $past(sel) |-> $stable(reg_select_addr) && $stable(read_write_dir);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or direction changed in a cycle");
  property p_dev_reset;
    !reset_in_n |=> transfer_ack_n && int_request_n && data_dev_oe_n;
  endproperty
  a_dev_reset: assert property (p_dev_reset)
    else $error("device outputs active during reset");
endmodule : ahbi_port_props

// >>> tb/async_host_bus_interface_tb.sv
// Bench joining controller and device through the port interface.
// Assumes the format pin low from reset, so the device answers.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module async_host_bus_interface_tb;
  logic aclk = 0, aresetn = 0, rxd_a = 1, rxd_b = 1, fmt = 0;
  logic [16:0] cond = '0;
  logic [15:0] io_in = '0, io_out, io_oe_n;
  logic txd_a, txd_b, irq, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [1:0] bresp, rresp;
  logic [6:0] clr [8] = '{ahbi_pkg::ADDR_IMR0, ahbi_pkg::ADDR_IMR1, ahbi_pkg::ADDR_IMR2,
    ahbi_pkg::ADDR_ISR0, ahbi_pkg::ADDR_ISR1, ahbi_pkg::ADDR_ISR2, ahbi_pkg::ADDR_OPR,
    ahbi_pkg::ADDR_OUT_PORT_CONFIG_REG};
  int num_errors = 0, checked = 0;
  integer seed = 32'h82b7_dc94;
  ahbi_port_if port ();
  ahbi_host ahbi_host_inst (.aclk(aclk), .aresetn(aresetn), .bus(port.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));
  // The format pin is only raised while the register forces acknowledge mode.
  ahbi_device ahbi_device_inst (.aclk(aclk), .aresetn(aresetn), .bus(port.device),
    .bus_fmt_sel(fmt), .rxd_a(rxd_a), .rxd_b(rxd_b), .int_cond(cond), .io_in(io_in),
    .txd_a(txd_a), .txd_b(txd_b), .io_out(io_out), .io_oe_n(io_oe_n));
  ahbi_port_props ahbi_port_props_inst (.aclk(aclk), .aresetn(aresetn),
    .chip_select_n(port.chip_select_n), .read_write_dir(port.read_write_dir),
    .int_ack_n(port.int_ack_n), .reset_in_n(port.reset_in_n),
    .reg_select_addr(port.reg_select_addr), .data_host_oe_n(port.data_host_oe_n),
    .data_dev_oe_n(port.data_dev_oe_n), .transfer_ack_n(port.transfer_ack_n),
    .int_request_n(port.int_request_n));
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic results();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    @(posedge aclk);
    awaddr <= {27'h0, a};
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 50 && bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end
    if (i == 50) begin num_errors++; results(); end
    bready <= 0;
    `CHK(bresp, e)
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] e);
    int i;
    @(posedge aclk);
    araddr <= {27'h0, a};
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 50 && rvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
    end
    if (i == 50) begin num_errors++; results(); end
    rready <= 0;
    d = rdata;
    `CHK(rresp, e)
  endtask : axi_rd
  // One port cycle ordered through the command register, then polled to its end.
  task automatic dev(input logic [9:0] op, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    int i;
    axi_wr(ahbi_pkg::HOFS_CMD, {8'h00, d, 6'h00, op}, ahbi_pkg::RESP_OKAY);
    r = 32'h0000_0100;
    for (i = 0; i < 20 && r[8] !== 1'b0; i++)
      axi_rd(ahbi_pkg::HOFS_RESULT, r, ahbi_pkg::RESP_OKAY);
    if (i == 20) begin num_errors++; results(); end
    q = r[7:0];
  endtask : dev
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    dev({3'b000, a}, d, q);
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    dev({3'b010, a}, 8'h00, q);
    `CHK(q, e)
  endtask : rdc
  initial
  begin
    repeat (50000) @(posedge aclk);
    num_errors++;
    results();
  end
  initial
  begin
    logic [7:0] v, m;
    logic [31:0] r;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    `CHK(txd_a & txd_b, ahbi_pkg::MARK)
    `CHK(io_oe_n, 16'hffff)
    `CHK(io_out, 16'h0000)
    `CHK(port.int_request_n, 1'b1)
    // The pin filter restarts from strobe mode, so the device answers only
    // once the low format pin has passed all three stages.
    repeat (4) @(posedge aclk);
    rdc(7'h00, ahbi_pkg::MODE1_RST);
    rdc(7'h00, ahbi_pkg::MODE2_RST);
    rdc(7'h08, ahbi_pkg::MODE1_RST);
    rdc(7'h0a, ahbi_pkg::BAUD_RST);
    rdc(7'h01, 8'h02);
    rdc(ahbi_pkg::ADDR_CT_CTRL, 8'h00);
    foreach (clr[k]) rdc(clr[k], 8'h00);
    $display("test reset done");
    dev(10'h200, 8'h00, m);
    `CHK(m, ahbi_pkg::VECTOR_RST)
    v = 8'($random(seed));
    wr(ahbi_pkg::ADDR_VECTOR, v);
    dev(10'h200, 8'h00, m);
    `CHK(m, v)
    $display("test vector done");
    repeat (4)
    begin
      v = 8'($random(seed));
      m = 8'($random(seed));
      wr(ahbi_pkg::ADDR_OPR, v);
      wr(ahbi_pkg::ADDR_OUT_PORT_CONFIG_REG, m);
      rdc(ahbi_pkg::ADDR_OPR, v);
      `CHK(io_out, {8'h00, v})
      `CHK(io_oe_n, {8'hff, ~m})
    end
    wr(7'h7f, 8'h5a);
    rdc(7'h7f, 8'h00);
    io_in <= 16'($random(seed));
    cond <= 17'($random(seed));
    repeat (6) @(posedge aclk);
    rdc(ahbi_pkg::ADDR_IOIN_B, io_in[15:8]);
    rdc(ahbi_pkg::ADDR_ISR1, cond[15:8]);
    $display("test access done");
    rxd_a <= 0;
    repeat (8) @(posedge aclk);
    rxd_a <= 1;
    repeat (8) @(posedge aclk);
    rdc(7'h01, 8'h03);
    rdc(7'h09, 8'h02);
    wr(7'h01, 8'h00);
    rdc(7'h01, 8'h02);
    $display("test serial done");
    cond <= 17'h1_0001;
    repeat (4) @(posedge aclk);
    `CHK(port.int_request_n, 1'b1)
    wr(ahbi_pkg::ADDR_IMR2, 8'h01);
    `CHK(port.int_request_n, 1'b0)
    axi_rd(ahbi_pkg::HOFS_INT_STATUS, r, ahbi_pkg::RESP_OKAY);
    `CHK({r[1], irq}, 2'h2)
    axi_wr(ahbi_pkg::HOFS_INT_MASK, 32'h0000_0002, ahbi_pkg::RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(ahbi_pkg::ADDR_IMR2, 8'h00);
    `CHK(port.int_request_n, 1'b1)
    axi_wr(ahbi_pkg::HOFS_INT_STATUS, 32'h0000_0003, ahbi_pkg::RESP_OKAY);
    axi_rd(ahbi_pkg::HOFS_INT_STATUS, r, ahbi_pkg::RESP_OKAY);
    `CHK({r[1:0], irq}, 3'h0)
    $display("test interrupt done");
    wr(ahbi_pkg::ADDR_BUSCFG, 8'h01);
    fmt <= 1;
    repeat (6) @(posedge aclk);
    rdc(ahbi_pkg::ADDR_BUSCFG, 8'h01);
    fmt <= 0;
    repeat (6) @(posedge aclk);
    $display("test bus format done");
    wr(ahbi_pkg::ADDR_OPR, 8'ha5);
    wr(ahbi_pkg::ADDR_IMR0, 8'hff);
    axi_wr(ahbi_pkg::HOFS_DEV_CTRL, 32'h0000_0000, ahbi_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK({port.int_request_n, io_oe_n}, 17'h1_ffff)
    axi_wr(ahbi_pkg::HOFS_DEV_CTRL, 32'h0000_0001, ahbi_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    rdc(ahbi_pkg::ADDR_OPR, 8'h00);
    rdc(ahbi_pkg::ADDR_IMR0, 8'h00);
    rdc(7'h00, ahbi_pkg::MODE1_RST);
    rdc(ahbi_pkg::ADDR_BUSCFG, 8'h00);
    $display("test device reset done");
    axi_wr(5'h14, 32'h0000_0001, ahbi_pkg::RESP_SLVERR);
    axi_rd(5'h1c, r, ahbi_pkg::RESP_SLVERR);
    `CHK(r, 32'h0000_0000)
    $display("test unmapped done");
    results();
  end
endmodule : async_host_bus_interface_tb
